// file: dv/rssm_host.sv
// Host model: takes output characters under random back-pressure and logs them
`timescale 1ns/1ps
`default_nettype none
module rssm_host (
	input wire logic i_clk,
	input wire logic i_stall,
	input wire logic i_valid,
	input wire logic [7:0] i_data,
	input wire logic i_is_k,
	input wire logic [2:0] i_code,
	output logic o_ready
);
	logic [11:0] seen_q[$];
	logic [7:0] lfsr = 8'hA5;
	initial o_ready = 1'b0;
	// ==========================================================
	// Accept on a ready edge, redraw ready just after it
	always @(posedge i_clk) begin
		if (o_ready && i_valid === 1'b1) seen_q.push_back({i_code, i_is_k, i_data});
		lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		#1 o_ready = !i_stall && lfsr[1:0] != 2'h0;
	end
endmodule // rssm_host
`default_nettype wire

// file: dv/rssm_top_test.sv
// Bench for the receive sync status machine
`timescale 1ns/1ps
`default_nettype none
module rssm_top_test;
	import rssm_pkg::*;
	localparam logic [7:0] FB = 8'hBC;
	logic clk, arst_n, pll, eb, bd, stall, o_cr, o_v, o_k, rdy, cv, vi, di, fr, ck;
	logic [1:0] mode;
	logic [12:0] drv;
	logic [7:0] cd, o_d;
	logic [2:0] o_code;
	logic [4:0] o_st;
	logic [13:0] exp_q[$];
	logic [31:0] seed = 32'd25;
	logic [31:0] r;
	logic [11:0] v, nx;
	logic [3:0] c;
	int miscompares = 0;
	int checks_done = 0;
	int cnt, h;
	assign {cv, vi, di, fr, ck, cd} = drv;
	rssm_top i_rssm_top (.I_CLK(clk), .I_ARST_N(arst_n), .I_RX_MODE_SELECT(mode),
		.I_CHAR_VALID(cv), .I_CHAR_DATA(cd), .I_CHAR_IS_K(ck), .I_FRAMING_CHAR_DET(fr),
		.I_CODE_VIOLATION(vi), .I_DISPARITY_ERR(di), .I_PLL_LOCKED(pll), .I_EBUF_FAULT(eb),
		.I_BONDED(bd), .O_CHAR_READY(o_cr), .O_VALID(o_v), .I_READY(rdy), .O_DATA(o_d),
		.O_IS_K(o_k), .O_RX_CHAR_STATUS_CODE(o_code), .O_SYNC_STATE(o_st));
	rssm_host i_rssm_host (.i_clk(clk), .i_stall(stall), .i_valid(o_v), .i_data(o_d),
		.i_is_k(o_k), .i_code(o_code), .o_ready(rdy));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// ==========================================================
	// Helpers
	function automatic logic [31:0] xorshift();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// {care code, care char, code, K, byte}; c is {viol, disp, frame, K}
	function automatic logic [13:0] expect_of(input logic [3:0] c, input logic [7:0] b);
		if (c[3]) return {2'h3, ST_VIOL, CHAR_C07};
		if (c[1]) return {2'h3, ST_FRAME, c[0], b};
		if (c[2]) return {2'h3, ST_DISP, CHAR_C47};
		return {2'h3, ST_NORMAL, c[0], b};
	endfunction
	task automatic check(input string what, input logic [13:0] e, input logic [13:0] g);
		checks_done++;
		if (e !== g) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic idle(input int n);
		drv = '0;
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Valid is raised only while the FIFO has room
	task automatic send(input logic [3:0] c, input logic [7:0] b, input int m);
		if (o_cr !== 1'b1) drv = '0;
		while (o_cr !== 1'b1) begin
			@(posedge clk);
			#1;
		end
		drv = {1'b1, c, b};
		@(posedge clk);
		#1;
		exp_q.push_back(m == 1 ? expect_of(c, b) : m == 2 ? {2'h2, ST_LOSS, 9'h0} : 14'h0);
	endtask
	task automatic frames(input int n);
		repeat (n) send(4'h3, FB, 0);
	endtask
	task automatic state_is(input string what, input logic [4:0] s);
		idle(4);
		check(what, {9'h0, s}, {9'h0, o_st});
	endtask
	task automatic settle();
		drv = '0;
		for (int n = 0; n < 3000 && i_rssm_host.seen_q.size() < exp_q.size(); n++) @(posedge clk);
		#1;
	endtask
	task automatic drain();
		logic [13:0] e;
		logic [11:0] g;
		settle();
		check("count", 14'(exp_q.size()), 14'(i_rssm_host.seen_q.size()));
		while (exp_q.size() > 0 && i_rssm_host.seen_q.size() > 0) begin
			e = exp_q.pop_front();
			g = i_rssm_host.seen_q.pop_front();
			if (e[13]) check("code", {11'h0, e[11:9]}, {11'h0, g[11:9]});
			if (e[12]) check("char", {5'h0, e[8:0]}, {5'h0, g[8:0]});
		end
		exp_q.delete();
	endtask
	task automatic scan(input logic [2:0] k, output int n, output logic [11:0] a, output logic [11:0] b);
		logic [11:0] q[$];
		q = i_rssm_host.seen_q;
		n = 0;
		a = '0;
		b = '0;
		foreach (q[i]) begin
			if (q[i][11:9] === k) begin
				n++;
				a = q[i];
				if (i + 1 < q.size()) b = q[i + 1];
			end
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// ==========================================================
	// Scenarios
	initial begin
		#300000;
		miscompares++;
		summarize();
	end
	initial begin
		arst_n = 1'b0;
		mode = 2'h2;
		{pll, eb, bd, stall} = 4'hA;
		drv = '0;
		repeat (8) @(posedge clk);
		#1;
		check("reset", {6'h0, ST_LOSS, S_NO_SYNC}, {5'h0, o_v, o_code, o_st});
		arst_n = 1'b1;
		idle(4);
		frames(1);
		send(4'h8, 8'h00, 0);
		state_is("abandon", S_NO_SYNC);
		frames(3);
		state_is("three frames", S_RESYNC);
		frames(3);
		state_is("synced", S_IN_SYNC);
		settle();
		scan(ST_RESYNC, h, v, nx);
		check("resync char", {2'h0, ST_RESYNC, 1'b1, FB}, {2'h0, v});
		drain();
		repeat (80) begin
			r = xorshift();
			c = r[2:0] == 3'h0 ? 4'h8 : r[2:0] == 3'h1 ? 4'h4 : r[2:0] == 3'h2 ? 4'h3 : 4'h0;
			send(c, c == 4'h3 ? FB : r[15:8], 1);
			if (c[3] | c[2]) send(4'h0, r[23:16], 1);
		end
		send(4'h7, FB, 1);
		send(4'h0, 8'h12, 1);
		send(4'hB, FB, 1);
		send(4'h0, 8'h34, 1);
		drain();
		stall = 1'b1;
		cnt = 0;
		while (o_cr === 1'b1 && cnt < 40) begin
			send(4'h0, 8'(cnt), 1);
			cnt++;
		end
		idle(4);
		check("fill", 14'h1, 14'(cnt >= 16 && cnt <= 18));
		check("refused", 14'h0, {13'h0, o_cr});
		stall = 1'b0;
		drain();
		eb = 1'b1;
		send(4'h0, 8'h5A, 2);
		eb = 1'b0;
		state_is("buffer fault", S_NO_SYNC);
		frames(6);
		repeat (3) send(4'h8, 8'h00, 1);
		state_is("three errors", S_IN_SYNC);
		send(4'h8, 8'h00, 0);
		state_is("four errors", S_NO_SYNC);
		send(4'h0, 8'h22, 2);
		frames(6);
		pll = 1'b0;
		state_is("pll lost", S_NO_SYNC);
		pll = 1'b1;
		idle(4);
		frames(6);
		repeat (3) send(4'h8, 8'h00, 1);
		send(4'h0, 8'h11, 1);
		send(4'h8, 8'h00, 1);
		state_is("imbalance 3", S_IN_SYNC);
		send(4'h8, 8'h00, 0);
		state_is("imbalance 4", S_NO_SYNC);
		drain();
		bd = 1'b0;
		frames(5);
		state_is("no bond", S_BOND_FAIL);
		send(4'h0, 8'h44, 0);
		state_is("bond fail data", S_NO_SYNC);
		frames(5);
		bd = 1'b1;
		state_is("late bond", S_IN_SYNC);
		eb = 1'b1;
		idle(4);
		eb = 1'b0;
		mode = 2'h3;
		idle(4);
		frames(6);
		repeat (4) send(4'h0, 8'(xorshift()), 0);
		state_is("type b sync", S_IN_SYNC);
		settle();
		scan(ST_LOCK, h, v, nx);
		check("lock once", 14'h1, 14'(h));
		check("after lock", {11'h0, ST_NORMAL}, {11'h0, nx[11:9]});
		send(4'h3, FB, 1);
		state_is("resync in sync", S_RESYNC_IN_SYNC);
		send(4'h0, 8'h66, 1);
		state_is("back in sync", S_IN_SYNC);
		eb = 1'b1;
		idle(4);
		{eb, bd} = 2'h0;
		frames(1);
		state_is("deskew start", S_RESYNC);
		idle(22);
		state_is("deskew", S_NO_SYNC);
		bd = 1'b1;
		mode = 2'h0;
		pll = 1'b0;
		idle(4);
		send(4'h0, 8'h33, 2);
		pll = 1'b1;
		idle(4);
		repeat (5) send(4'h0, 8'(xorshift()), 1);
		drain();
		mode = 2'h2;
		idle(4);
		frames(5);
		state_is("before reset", S_IN_SYNC);
		drain();
		arst_n = 1'b0;
		#1;
		check("reset again", {6'h0, ST_LOSS, S_NO_SYNC}, {5'h0, o_v, o_code, o_st});
		repeat (2) @(posedge clk);
		#1;
		arst_n = 1'b1;
		state_is("after reset", S_NO_SYNC);
		frames(5);
		state_is("resynced", S_IN_SYNC);
		drain();
		summarize();
	end
endmodule // rssm_top_test
`default_nettype wire

// file: hdl/rssm_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module rssm_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 16
) (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [WIDTH-1:0] i_data,
	output logic o_valid,
	input wire logic i_ready,
	output logic [WIDTH-1:0] o_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic [AW:0] cnt_d;
	logic ready_q;
	logic push;
	logic pop;
	// Not-full flag kept in a flop, equal to a compare on the count
	assign o_ready = ready_q;
	assign o_valid = (cnt_q != '0);
	assign o_data = mem[rd_q];
	assign push = i_valid & o_ready;
	assign pop = o_valid & i_ready;
	assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wr_q] <= i_data;
		end
	end
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			ready_q <= 1'b1;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
			cnt_q <= cnt_d;
			ready_q <= (cnt_d != (AW+1)'(DEPTH));
		end
	end
endmodule // rssm_fifo
`default_nettype wire

// file: hdl/rssm_pkg.sv
// Package: constants and types for the receive sync status machine
package rssm_pkg;
	// ==========================================================
	// Status codes
	localparam logic [2:0] ST_NORMAL = 3'h0;
	localparam logic [2:0] ST_LOCK = 3'h2;
	localparam logic [2:0] ST_FRAME = 3'h3;
	localparam logic [2:0] ST_VIOL = 3'h4;
	localparam logic [2:0] ST_LOSS = 3'h5;
	localparam logic [2:0] ST_DISP = 3'h6;
	localparam logic [2:0] ST_RESYNC = 3'h7;
	// ==========================================================
	// Special characters {K flag, byte}
	localparam logic [8:0] CHAR_C07 = 9'h1E0;
	localparam logic [8:0] CHAR_C47 = 9'h1E4;
	// ==========================================================
	// Counts
	localparam logic [2:0] FRAME_LOCK_CNT = 3'h4;
	localparam logic [2:0] DEC_ERR_CNT = 3'h4;
	localparam logic signed [3:0] INV_MINUS_VAL = 4'sh4;
	localparam int DESKEW_TIME_NS = 80;
	localparam int CLK_PERIOD_NS = 5;
	localparam logic [7:0] DESKEW_CYC = 8'((DESKEW_TIME_NS) / CLK_PERIOD_NS);
	// ==========================================================
	// FIFO shape
	localparam int FIFO_WIDTH = 12;
	localparam int FIFO_DEPTH = 16;
	// ==========================================================
	// Mode bits
	localparam int MODE_TYPE_BIT = 0;
	localparam int MODE_BOND_BIT = 1;
	typedef enum logic [4:0] {
		S_NO_SYNC = 5'h01,
		S_RESYNC = 5'h02,
		S_IN_SYNC = 5'h04,
		S_BOND_FAIL = 5'h08,
		S_RESYNC_IN_SYNC = 5'h10
	} rssm_state_type;
endpackage

// file: hdl/rssm_top.sv
// Receive synchronization state machine and character status encoder
// How it works
// - State machine only runs when bonding selected
// - Valid data character reports code 000
// - Type-B channel lock reports code 010
// - Lock code only on cycle before data
// - Framing character reports 011 with its value
// - Undecodable character reports 100 with C0.7
// - Lost framing or alignment reports 101
// - Independent mode: PLL unlock reports 101
// - Elasticity buffer fault reports 101
// - Disparity error reports 110 with C4.7
// - Resync state reports 111 with framing char
// - Type-A syncs after five framing characters (one enters resync, four more lock)
// - Sync lost on fault, errors, or imbalance
// - Type-A resync abandoned on any error
// - Valid non-framing character moves Type-A machine from bond fail to no sync
// - Type-B deskew expiry or error fails
// - Type-B moves on first valid data character after framing
`timescale 1ns/1ps
`default_nettype none
module rssm_top
	import rssm_pkg::*;
(
	input wire logic I_CLK,
	input wire logic I_ARST_N,
	input wire logic [1:0] I_RX_MODE_SELECT,
	input wire logic I_CHAR_VALID,
	input wire logic [7:0] I_CHAR_DATA,
	input wire logic I_CHAR_IS_K,
	input wire logic I_FRAMING_CHAR_DET,
	input wire logic I_CODE_VIOLATION,
	input wire logic I_DISPARITY_ERR,
	input wire logic I_PLL_LOCKED,
	input wire logic I_EBUF_FAULT,
	input wire logic I_BONDED,
	output logic O_CHAR_READY,
	output logic O_VALID,
	input wire logic I_READY,
	output logic [7:0] O_DATA,
	output logic O_IS_K,
	output logic [2:0] O_RX_CHAR_STATUS_CODE,
	output logic [4:0] O_SYNC_STATE
);
	import rssm_pkg::*;

	// ==========================================================
	// Input synchronisers for asynchronous levels
	logic [1:0] pll_s_q;
	logic [1:0] mode_s0_q;
	logic [1:0] mode_s1_q;
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			pll_s_q <= 2'h0;
			mode_s0_q <= 2'h0;
			mode_s1_q <= 2'h0;
		end else begin
			pll_s_q <= {pll_s_q[0], I_PLL_LOCKED};
			mode_s0_q <= I_RX_MODE_SELECT;
			mode_s1_q <= mode_s0_q;
		end
	end
	logic pll_lock;
	logic bond_en;
	logic type_b;
	assign pll_lock = pll_s_q[1];
	assign bond_en = mode_s1_q[MODE_BOND_BIT];
	assign type_b = mode_s1_q[MODE_TYPE_BIT];

	// ==========================================================
	// Character classification
	logic fifo_ready;
	logic take;
	logic dec_err;
	logic fault;
	logic good_data;
	assign take = I_CHAR_VALID & fifo_ready;
	assign dec_err = I_CODE_VIOLATION | I_DISPARITY_ERR;
	assign fault = I_EBUF_FAULT | ~pll_lock;
	assign good_data = ~dec_err & ~I_FRAMING_CHAR_DET;
	assign O_CHAR_READY = fifo_ready;

	// ==========================================================
	// Counters
	rssm_state_type state_q;
	rssm_state_type state_d;
	logic [2:0] frame_cnt_q;
	logic [2:0] err_cnt_q;
	logic signed [3:0] bal_q;
	logic [7:0] deskew_q;
	logic lost_sync;
	assign lost_sync = fault | (take & dec_err & (err_cnt_q == DEC_ERR_CNT - 3'h1))
		| (take & dec_err & (bal_q == INV_MINUS_VAL - 4'sh1));
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			frame_cnt_q <= 3'h0;
		end else if (state_q != state_d) begin
			frame_cnt_q <= 3'h0;
		end else if (take) begin
			if (I_FRAMING_CHAR_DET && !dec_err) begin
				if (frame_cnt_q != FRAME_LOCK_CNT) begin
					frame_cnt_q <= frame_cnt_q + 3'h1;
				end
			end else begin
				frame_cnt_q <= 3'h0;
			end
		end
	end
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			err_cnt_q <= 3'h0;
			bal_q <= 4'sh0;
		end else if (state_q != state_d) begin
			err_cnt_q <= 3'h0;
			bal_q <= 4'sh0;
		end else if (take) begin
			if (dec_err) begin
				if (err_cnt_q != DEC_ERR_CNT) begin
					err_cnt_q <= err_cnt_q + 3'h1;
				end
				if (bal_q != INV_MINUS_VAL) begin
					bal_q <= bal_q + 4'sh1;
				end
			end else begin
				err_cnt_q <= 3'h0;
				if (bal_q != 4'sh0) begin
					bal_q <= bal_q - 4'sh1;
				end
			end
		end
	end
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			deskew_q <= 8'h0;
		end else if (state_q != S_RESYNC) begin
			deskew_q <= DESKEW_CYC;
		end else if (deskew_q != 8'h0) begin
			deskew_q <= deskew_q - 8'h1;
		end
	end

	// ==========================================================
	// State machine
	always_comb begin
		state_d = state_q;
		case (state_q)
			S_NO_SYNC: begin
				if (take && I_FRAMING_CHAR_DET && !dec_err && !fault) begin
					state_d = S_RESYNC;
				end
			end
			S_RESYNC: begin
				if (fault || (take && dec_err)) begin
					state_d = S_NO_SYNC;
				end else if (type_b && deskew_q == 8'h0 && !I_BONDED) begin
					state_d = S_NO_SYNC;
				end else if (!type_b && take && I_FRAMING_CHAR_DET
					&& frame_cnt_q == FRAME_LOCK_CNT - 3'h1) begin
					state_d = I_BONDED ? S_IN_SYNC : S_BOND_FAIL;
				end else if (type_b && take && good_data && I_BONDED) begin
					state_d = S_IN_SYNC;
				end
			end
			S_BOND_FAIL: begin
				if (fault || (take && dec_err)) begin
					state_d = S_NO_SYNC;
				end else if (take && good_data) begin
					state_d = S_NO_SYNC;
				end else if (I_BONDED) begin
					state_d = S_IN_SYNC;
				end
			end
			S_IN_SYNC: begin
				if (lost_sync) begin
					state_d = S_NO_SYNC;
				end else if (type_b && take && I_FRAMING_CHAR_DET && !dec_err) begin
					state_d = S_RESYNC_IN_SYNC;
				end
			end
			S_RESYNC_IN_SYNC: begin
				if (lost_sync || (take && dec_err)) begin
					state_d = S_NO_SYNC;
				end else if (take && good_data) begin
					state_d = S_IN_SYNC;
				end
			end
			default: begin
				state_d = S_NO_SYNC;
			end
		endcase
		if (!bond_en) begin
			state_d = S_NO_SYNC;
		end
	end
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			state_q <= S_NO_SYNC;
		end else begin
			state_q <= state_d;
		end
	end

	// ==========================================================
	// Status encoder, priority: loss, lock, resync, violation, framing, disparity
	logic [2:0] code;
	logic [8:0] out_char;
	logic lock_now;
	// lock on cycle before aligned data
	assign lock_now = type_b && state_q == S_RESYNC && state_d == S_IN_SYNC;
	always_comb begin
		code = ST_NORMAL;
		out_char = {I_CHAR_IS_K, I_CHAR_DATA};
		if (!bond_en) begin
			if (fault) begin
				code = ST_LOSS;
			end else if (I_CODE_VIOLATION) begin
				code = ST_VIOL;
				out_char = CHAR_C07;
			end else if (I_FRAMING_CHAR_DET) begin
				code = ST_FRAME;
			end else if (I_DISPARITY_ERR) begin
				code = ST_DISP;
				out_char = CHAR_C47;
			end
		end else if (fault || state_q == S_NO_SYNC || state_d == S_NO_SYNC) begin
			code = ST_LOSS;
		end else if (lock_now) begin
			code = ST_LOCK;
		end else if (state_q == S_RESYNC && !type_b) begin
			code = ST_RESYNC;
		end else if (state_q == S_RESYNC) begin
			code = ST_RESYNC;
		end else if (I_CODE_VIOLATION) begin
			code = ST_VIOL;
			out_char = CHAR_C07;
		end else if (I_FRAMING_CHAR_DET) begin
			code = ST_FRAME;
		end else if (I_DISPARITY_ERR) begin
			code = ST_DISP;
			out_char = CHAR_C47;
		end
	end

	// ==========================================================
	// Output FIFO
	logic [11:0] fifo_out;
	logic fifo_valid;
	rssm_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_clk(I_CLK),
		.i_arst_n(I_ARST_N),
		.i_valid(I_CHAR_VALID),
		.o_ready(fifo_ready),
		.i_data({code, out_char}),
		.o_valid(fifo_valid),
		.i_ready(I_READY | ~O_VALID),
		.o_data(fifo_out)
	);
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			O_VALID <= 1'b0;
			O_DATA <= 8'h0;
			O_IS_K <= 1'b0;
			O_RX_CHAR_STATUS_CODE <= ST_LOSS;
		end else if (I_READY || !O_VALID) begin
			O_VALID <= fifo_valid;
			if (fifo_valid) begin
				O_RX_CHAR_STATUS_CODE <= fifo_out[11:9];
				O_IS_K <= fifo_out[8];
				O_DATA <= fifo_out[7:0];
			end
		end
	end
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			O_SYNC_STATE <= S_NO_SYNC;
		end else begin
			O_SYNC_STATE <= state_d;
		end
	end

	// ==========================================================
	// Checks
	reset_state_a: assert property (@(posedge I_CLK)
		$rose(I_ARST_N) |-> state_q == S_NO_SYNC)
		else $error("not unsynchronized after reset");
	fault_drop_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		(bond_en && fault) |=> state_q == S_NO_SYNC || !bond_en)
		else $error("fault did not drop sync");
	viol_char_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		code == ST_VIOL |-> out_char == CHAR_C07)
		else $error("violation without C0.7");
	loss_code_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		(bond_en && state_q == S_NO_SYNC) |-> code == ST_LOSS)
		else $error("no loss code out of sync");
	lock_once_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		code == ST_LOCK |=> code != ST_LOCK)
		else $error("lock code repeated");
	resync_err_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		(bond_en && state_q == S_RESYNC && take && dec_err) |=> state_q == S_NO_SYNC)
		else $error("resync kept after error");
	disp_char_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		code == ST_DISP |-> out_char == CHAR_C47)
		else $error("disparity without C4.7");
	indep_loss_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		(!bond_en && fault) |-> code == ST_LOSS)
		else $error("independent unlock not reported");
	lock_next_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		(bond_en && code == ST_LOCK) |=> state_q == S_IN_SYNC)
		else $error("lock code not followed by aligned data");
	deskew_fail_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		(bond_en && type_b && state_q == S_RESYNC && deskew_q == 8'h0 && !I_BONDED) |=> state_q == S_NO_SYNC)
		else $error("deskew expiry kept resync");
	resync_code_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		(bond_en && !fault && state_q == S_RESYNC && state_d == S_RESYNC)
		|-> code == ST_RESYNC && out_char == {I_CHAR_IS_K, I_CHAR_DATA})
		else $error("resync state without resync code");
	frame_code_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		(bond_en && !fault && state_q == S_IN_SYNC && state_d == S_IN_SYNC && I_FRAMING_CHAR_DET
		&& !I_CODE_VIOLATION) |-> code == ST_FRAME && out_char == {I_CHAR_IS_K, I_CHAR_DATA})
		else $error("framing character not reported");
	frame_lock_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		(bond_en && !type_b && state_q == S_RESYNC && state_d != S_NO_SYNC && state_d != S_RESYNC)
		|-> frame_cnt_q == FRAME_LOCK_CNT - 3'h1)
		else $error("sync declared before four framing characters");
endmodule // rssm_top
`default_nettype wire
